// ===== inc/daa_line_pkg.sv
// Shared constants for the line control register bank
package daa_line_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] RING_INDICATOR_CONFIG_IDX  = 8'h0E;
   localparam logic [7:0] PATH_MUTE_CONTROL_IDX      = 8'h0F;
   localparam logic [7:0] LINE_INTERFACE_CONTROL_IDX = 8'h10;
   localparam logic [7:0] THRESHOLD_EXT_CONTROL_IDX  = 8'h11;
   localparam logic [7:0] HOOK_CONTROL_IDX           = 8'h20;
   localparam logic [7:0] LINE_STATUS_IDX            = 8'h21;
   localparam int         ADDR_W                     = 12;

   // Field positions
   localparam int RING_POLARITY_BIT    = 1;
   localparam int TRANSMIT_MUTE_BIT    = 7;
   localparam int RECEIVE_MUTE_BIT     = 3;
   localparam int HOOK_SPEED_BIT       = 6;
   localparam int IIR_SELECT_BIT       = 4;
   localparam int RINGER_IMP_BIT       = 1;
   localparam int THRESHOLD_BIT        = 0;
   localparam int THRESHOLD_EXT_BIT    = 4;
   localparam int OFF_HOOK_BIT         = 0;
   localparam int HOOK_SPEED_EXT_BIT   = 1;
   localparam int QUENCH_LSB           = 2;
   localparam int RELEASE_ACTIVE_BIT   = 0;
   localparam int THRESHOLD_REJECT_BIT = 1;

   // Writable bit masks; other bits read as zero
   localparam logic [7:0] RING_INDICATOR_MASK = 8'h02;
   localparam logic [7:0] PATH_MUTE_MASK      = 8'h88;
   localparam logic [7:0] LINE_IF_MASK        = 8'hF3;
   localparam logic [7:0] THRESHOLD_EXT_MASK  = 8'h10;
   localparam logic [7:0] HOOK_CONTROL_MASK   = 8'h0F;

   // Values after reset
   localparam logic [7:0] REG_RESET = 8'h00;

   // Hook release times and clock rate
   localparam int CLK_KHZ            = 10000;
   localparam int HOOK_ETSI_TIME_US  = 3000;
   localparam int HOOK_QUENCH_TIME_US = 26000;
   localparam int HOOK_ETSI_CYCLES   = HOOK_ETSI_TIME_US * CLK_KHZ / 1000;
   localparam int HOOK_QUENCH_CYCLES = HOOK_QUENCH_TIME_US * CLK_KHZ / 1000;
   localparam int HOOK_FAST_CYCLES   = 1;
   localparam int HOOK_COUNT_W       = 19;

   // Spark quench encodings
   localparam logic [1:0] QUENCH_OFF  = 2'h0;
   localparam logic [1:0] QUENCH_FULL = 2'h3;

   localparam int SAMPLE_W = 16;
endpackage

// ===== test/daa_line_control_regs_chk.sv
// Port assertions for the line control register bank
`timescale 1ns/1ns
module daa_line_control_regs_chk (
   input wire logic                                pclk,
   input wire logic                                presetn,
   input wire logic                                psel,
   input wire logic                                penable,
   input wire logic [31:0]                         prdata,
   input wire logic                                pready,
   input wire logic                                pslverr,
   input wire logic                                ring_detect,
   input wire logic [daa_line_pkg::SAMPLE_W-1:0]   tx_sample_in,
   input wire logic [daa_line_pkg::SAMPLE_W-1:0]   rx_sample_in,
   input wire logic [daa_line_pkg::SAMPLE_W-1:0]   tx_sample_out,
   input wire logic [daa_line_pkg::SAMPLE_W-1:0]   rx_sample_out,
   input wire logic                                ring_indicator_pin,
   input wire logic                                iir_filter_select,
   input wire logic                                ringer_impedance_select,
   input wire logic [1:0]                          ring_threshold_level,
   input wire logic                                line_off_hook
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_no_wait: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_read_upper_zero: assert property (
      pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_tx_path: assert property (
      tx_sample_out == $past(tx_sample_in) || tx_sample_out == 16'h0000)
      else $error("transmit output neither sample nor silence");
   a_rx_path: assert property (
      rx_sample_out == $past(rx_sample_in) || rx_sample_out == 16'h0000)
      else $error("receive output neither sample nor silence");
   a_ring_pin_hold: assert property (
      !$past(psel, 2) && $past(ring_detect) == $past(ring_detect, 2)
      |-> $stable(ring_indicator_pin))
      else $error("ring pin moved without cause");
   a_cfg_hold: assert property (
      !$past(psel, 2) |-> $stable({iir_filter_select,
         ringer_impedance_select, ring_threshold_level}))
      else $error("line settings moved without a write");
   a_hook_rise: assert property (
      $rose(line_off_hook) |-> $past(psel, 2))
      else $error("off hook rose without a write");
endmodule // daa_line_control_regs_chk

bind daa_line_control_regs daa_line_control_regs_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ring_detect(ring_detect), .tx_sample_in(tx_sample_in),
   .rx_sample_in(rx_sample_in), .tx_sample_out(tx_sample_out),
   .rx_sample_out(rx_sample_out), .ring_indicator_pin(ring_indicator_pin),
   .iir_filter_select(iir_filter_select),
   .ringer_impedance_select(ringer_impedance_select),
   .ring_threshold_level(ring_threshold_level),
   .line_off_hook(line_off_hook));

// ===== test/daa_line_control_regs_tb.sv
// Self-checking bench for the line control register bank
`timescale 1ns/1ns
module daa_line_control_regs_tb;
   typedef struct {logic [11:0] a; logic [7:0] d, q; logic e;} reg_row_s;
   typedef struct {logic [11:0] a; logic [7:0] d; logic [3:0] o;} cfg_row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  pstrb, strb;
   logic        ring_detect, ring_indicator_pin, iir, rz, line_off_hook, e;
   logic [15:0] tx_in, rx_in, tx_out, rx_out;
   logic [1:0]  level;
   int          fails, check_count;
   reg_row_s    regs_t [8] = '{'{12'h038, 8'hFF, 8'h02, 1'b0},
      '{12'h03C, 8'hFF, 8'h88, 1'b0}, '{12'h040, 8'hFF, 8'hF3, 1'b0},
      '{12'h044, 8'hFF, 8'h10, 1'b0}, '{12'h0C0, 8'hFF, 8'h00, 1'b1},
      '{12'h03A, 8'h00, 8'h02, 1'b1}, '{12'h038, 8'h00, 8'h00, 1'b0},
      '{12'h03C, 8'h00, 8'h00, 1'b0}};
   cfg_row_s    cfg_t [5] = '{'{12'h040, 8'h13, 4'hF},
      '{12'h044, 8'h00, 4'hE}, '{12'h044, 8'h10, 4'hF},
      '{12'h040, 8'h02, 4'h7}, '{12'h044, 8'h00, 4'h4}};

   daa_line_control_regs #(.HOOK_ETSI_CYCLES(20), .HOOK_QUENCH_CYCLES(40))
   DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ring_detect(ring_detect), .tx_sample_in(tx_in), .rx_sample_in(rx_in),
      .tx_sample_out(tx_out), .rx_sample_out(rx_out),
      .ring_indicator_pin(ring_indicator_pin), .iir_filter_select(iir),
      .ringer_impedance_select(rz), .ring_threshold_level(level),
      .line_off_hook(line_off_hook));

   // Clock at 100 ns period
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string n, input logic [31:0] s, x);
      check_count++;
      if (s !== x) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, x, s);
      end
   endtask

   // One APB transfer, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] r,
                      output logic er);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         close_out;
      end
      r = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, q, e);
   endtask

   task automatic hook_case(input logic [7:0] sp, on, input int n);
      int c;
      c = 0;
      wr(12'h040, sp);
      wr(12'h080, on);
      @(posedge pclk);
      check("off hook", line_off_hook, 1);
      wr(12'h080, on & 8'hFE);
      while (line_off_hook === 1'b1 && c < 100) begin
         @(posedge pclk);
         c++;
      end
      check("release time", 32'(c >= n && c <= n + 4), 1);
   endtask

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF; strb = 4'hF;
      ring_detect = 1'b0; tx_in = 16'h1234; rx_in = 16'hABCD;
      fails = 0; check_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("idle ring pin", ring_indicator_pin, 1);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, regs_t[i].a, 8'h00, q, e);
         check("reset value", q, 0);
      end
      // Register rows: write, read back, error flag
      foreach (regs_t[i]) begin
         wr(regs_t[i].a, regs_t[i].d);
         apb(1'b0, regs_t[i].a, 8'h00, q, e);
         check("read back", q, {24'h0, regs_t[i].q});
         check("error flag", e, regs_t[i].e);
      end
      // Line settings rows
      foreach (cfg_t[i]) begin
         wr(cfg_t[i].a, cfg_t[i].d);
         @(posedge pclk);
         check("line settings", {iir, rz, level}, cfg_t[i].o);
      end
      $display("register and settings tests done");
      // Reserved threshold combination is flagged
      wr(12'h044, 8'h10);
      apb(1'b0, 12'h084, 8'h00, q, e);
      check("reserved flag", q[1], 1);
      wr(12'h044, 8'h00);
      wr(12'h03C, 8'h80);
      @(posedge pclk);
      check("tx muted", tx_out, 0);
      check("rx open", rx_out, 16'hABCD);
      wr(12'h03C, 8'h08);
      @(posedge pclk);
      check("tx open", tx_out, 16'h1234);
      check("rx muted", rx_out, 0);
      $display("mute test done");
      ring_detect <= 1'b1;
      repeat (2) @(posedge pclk);
      check("ring low active", ring_indicator_pin, 0);
      wr(12'h038, 8'h02);
      @(posedge pclk);
      check("ring high active", ring_indicator_pin, 1);
      ring_detect <= 1'b0;
      wr(12'h038, 8'h00);
      $display("ring polarity test done");
      hook_case(8'h00, 8'h03, 20);
      hook_case(8'h40, 8'h0D, 40);
      hook_case(8'h00, 8'h01, 1);
      $display("hook release test done");
      strb = 4'h0;
      wr(12'h038, 8'h02);
      strb = 4'hF;
      apb(1'b0, 12'h038, 8'h00, q, e);
      check("masked write", q, 0);
      wr(12'h03C, 8'h88);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h03C, 8'h00, q, e);
      check("mid-run reset", q, 0);
      $display("strobe and reset tests done");
      close_out;
   end
endmodule // daa_line_control_regs_tb

// ===== verilog/daa_line_control_regs.sv
// Line control register bank with APB access and line side controls
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module daa_line_control_regs #(
   parameter int HOOK_ETSI_CYCLES   = daa_line_pkg::HOOK_ETSI_CYCLES,
   parameter int HOOK_QUENCH_CYCLES = daa_line_pkg::HOOK_QUENCH_CYCLES
) (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [daa_line_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                      pwdata,
   input  wire logic [3:0]                       pstrb,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic                             ring_detect,
   input  wire logic [daa_line_pkg::SAMPLE_W-1:0] tx_sample_in,
   input  wire logic [daa_line_pkg::SAMPLE_W-1:0] rx_sample_in,
   output logic      [daa_line_pkg::SAMPLE_W-1:0] tx_sample_out,
   output logic      [daa_line_pkg::SAMPLE_W-1:0] rx_sample_out,
   output logic                                  ring_indicator_pin,
   output logic                                  iir_filter_select,
   output logic                                  ringer_impedance_select,
   output logic      [1:0]                       ring_threshold_level,
   output logic                                  line_off_hook
);
   localparam int CW = daa_line_pkg::HOOK_COUNT_W;

   logic [7:0]    ring_indicator_config;
   logic [7:0]    path_mute_control;
   logic [7:0]    line_interface_control;
   logic [7:0]    threshold_ext_control;
   logic [7:0]    hook_control;
   logic          threshold_reject;
   logic          setup_phase;
   logic          write_now;
   logic [7:0]    word_index;
   logic          index_hit;
   logic          address_ok;
   logic [7:0]    read_value;
   logic [7:0]    wbyte;
   logic          off_hook_control;
   logic          off_hook_prev;
   logic          hook_release_start;
   logic [CW-1:0] hook_release_cycles;
   logic          release_busy;
   logic          next_threshold_sel;
   logic          next_threshold_ext;

   // Address decode: word aligned, index is byte address over four
   assign setup_phase = psel && !penable;
   assign write_now   = psel && penable && pwrite && pready;
   assign word_index  = paddr[9:2];
   assign address_ok  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
   assign wbyte       = pwdata[7:0];

   always_comb begin
      case (word_index)
         daa_line_pkg::RING_INDICATOR_CONFIG_IDX,
         daa_line_pkg::PATH_MUTE_CONTROL_IDX,
         daa_line_pkg::LINE_INTERFACE_CONTROL_IDX,
         daa_line_pkg::THRESHOLD_EXT_CONTROL_IDX,
         daa_line_pkg::HOOK_CONTROL_IDX,
         daa_line_pkg::LINE_STATUS_IDX: index_hit = address_ok;
         default:                       index_hit = 1'b0;
      endcase
   end

   // Read mux; masked registers keep reserved bits at zero
   always_comb begin
      read_value = 8'h00;
      case (word_index)
         daa_line_pkg::RING_INDICATOR_CONFIG_IDX:
            read_value = ring_indicator_config;
         daa_line_pkg::PATH_MUTE_CONTROL_IDX:
            read_value = path_mute_control;
         daa_line_pkg::LINE_INTERFACE_CONTROL_IDX:
            read_value = line_interface_control;
         daa_line_pkg::THRESHOLD_EXT_CONTROL_IDX:
            read_value = threshold_ext_control;
         daa_line_pkg::HOOK_CONTROL_IDX:
            read_value = hook_control;
         daa_line_pkg::LINE_STATUS_IDX: begin
            read_value[daa_line_pkg::RELEASE_ACTIVE_BIT]   = release_busy;
            read_value[daa_line_pkg::THRESHOLD_REJECT_BIT] = threshold_reject;
         end
         default: read_value = 8'h00;
      endcase
   end

   // Zero wait state answer: pready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase && !index_hit;
         if (setup_phase && !pwrite) begin
            prdata <= {24'h000000, read_value};
         end else if (!psel) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Control register writes, low byte lane only
   // reserved bits masked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ring_indicator_config  <= daa_line_pkg::REG_RESET;
         path_mute_control      <= daa_line_pkg::REG_RESET;
         line_interface_control <= daa_line_pkg::REG_RESET;
         threshold_ext_control  <= daa_line_pkg::REG_RESET;
         hook_control           <= daa_line_pkg::REG_RESET;
      end else if (write_now && index_hit && pstrb[0] && !pslverr) begin
         case (word_index)
            daa_line_pkg::RING_INDICATOR_CONFIG_IDX:
               ring_indicator_config <=
                  wbyte & daa_line_pkg::RING_INDICATOR_MASK;
            daa_line_pkg::PATH_MUTE_CONTROL_IDX:
               path_mute_control <= wbyte & daa_line_pkg::PATH_MUTE_MASK;
            daa_line_pkg::LINE_INTERFACE_CONTROL_IDX:
               line_interface_control <= wbyte & daa_line_pkg::LINE_IF_MASK;
            daa_line_pkg::THRESHOLD_EXT_CONTROL_IDX:
               threshold_ext_control <=
                  wbyte & daa_line_pkg::THRESHOLD_EXT_MASK;
            daa_line_pkg::HOOK_CONTROL_IDX:
               hook_control <= wbyte & daa_line_pkg::HOOK_CONTROL_MASK;
            default: hook_control <= hook_control;
         endcase
      end
   end

   // Ring indicator pin follows detector at selected level
   // polarity select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ring_indicator_pin <= 1'b1;
      end else if (
         ring_indicator_config[daa_line_pkg::RING_POLARITY_BIT]) begin
         ring_indicator_pin <= ring_detect;
      end else begin
         ring_indicator_pin <= !ring_detect;
      end
   end

   // Audio paths, zeroed while muted
   // transmit mute
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sample_out <= '0;
      end else if (path_mute_control[daa_line_pkg::TRANSMIT_MUTE_BIT]) begin
         tx_sample_out <= '0;
      end else begin
         tx_sample_out <= tx_sample_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sample_out <= '0;
      end else if (path_mute_control[daa_line_pkg::RECEIVE_MUTE_BIT]) begin
         rx_sample_out <= '0;
      end else begin
         rx_sample_out <= rx_sample_in;
      end
   end

   // Filter and ringer impedance selects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iir_filter_select       <= 1'b0;
         ringer_impedance_select <= 1'b0;
      end else begin
         iir_filter_select <=
            line_interface_control[daa_line_pkg::IIR_SELECT_BIT];
         ringer_impedance_select <=
            line_interface_control[daa_line_pkg::RINGER_IMP_BIT];
      end
   end

   // Threshold pair: reserved combination keeps the last good level
   assign next_threshold_sel =
      line_interface_control[daa_line_pkg::THRESHOLD_BIT];
   assign next_threshold_ext =
      threshold_ext_control[daa_line_pkg::THRESHOLD_EXT_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ring_threshold_level <= 2'h0;
         threshold_reject     <= 1'b0;
      end else if (!next_threshold_sel && next_threshold_ext) begin
         threshold_reject <= 1'b1;
      end else begin
         ring_threshold_level <= {next_threshold_sel, next_threshold_ext};
         threshold_reject     <= 1'b0;
      end
   end

   // Hook release time from speed, extended speed and quench field
   assign off_hook_control = hook_control[daa_line_pkg::OFF_HOOK_BIT];

   always_comb begin
      hook_release_cycles = CW'(daa_line_pkg::HOOK_FAST_CYCLES);
      if (line_interface_control[daa_line_pkg::HOOK_SPEED_BIT] &&
          hook_control[daa_line_pkg::QUENCH_LSB +: 2] ==
          daa_line_pkg::QUENCH_FULL) begin
         hook_release_cycles = CW'(HOOK_QUENCH_CYCLES);
      end else if (!line_interface_control[daa_line_pkg::HOOK_SPEED_BIT] &&
                   hook_control[daa_line_pkg::HOOK_SPEED_EXT_BIT] &&
                   hook_control[daa_line_pkg::QUENCH_LSB +: 2] ==
                   daa_line_pkg::QUENCH_OFF) begin
         hook_release_cycles = CW'(HOOK_ETSI_CYCLES);
      end
   end

   // Falling edge of off-hook control starts the release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_hook_prev <= 1'b0;
      end else begin
         off_hook_prev <= off_hook_control;
      end
   end

   assign hook_release_start = off_hook_prev && !off_hook_control;

   hook_release_timer #(
      .COUNT_W (CW)
   ) u_hook_release_timer (
      .pclk        (pclk),
      .presetn     (presetn),
      .start       (hook_release_start),
      .load_cycles (hook_release_cycles),
      .busy        (release_busy)
   );

   // Line held off hook until release time elapses
   // loop held during release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_off_hook <= 1'b0;
      end else begin
         line_off_hook <= off_hook_control || hook_release_start ||
                          release_busy;
      end
   end
endmodule // daa_line_control_regs

// ===== verilog/hook_release_timer.sv
// Down counter that times the on-hook transition
`timescale 1ns/1ns
module hook_release_timer #(
   parameter int COUNT_W = 19
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               start,
   input  wire logic [COUNT_W-1:0] load_cycles,
   output logic                    busy
);
   logic [COUNT_W-1:0] remaining;

   // Load on start, count down to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remaining <= '0;
         busy      <= 1'b0;
      end else if (start) begin
         remaining <= load_cycles;
         busy      <= 1'b1;
      end else if (busy) begin
         if (remaining <= COUNT_W'(1)) begin
            busy <= 1'b0;
         end
         remaining <= remaining - COUNT_W'(1);
      end
   end
endmodule // hook_release_timer
